// ==== hdl/rscr_consts.svh ====
// constants of the reset and stop recovery controller
//
// Behaviour
// R1 - outside stop, power-on, brownout, watchdog, pin or debugger request starts a reset
// R2 - watchdog time-out resets only while the watchdog reset option is enabled; in stop the code starts recovery on a time-out whatever the option
// R3 - writing one to debugger control bit zero requests a device reset
// R4 - in stop, watchdog, enabled port transition or low debug pin start recovery
// R5 - only port pins with recovery enable set may trigger stop recovery
// R6 - exactly two reset types: full system reset and stop recovery
// R7 - reset type chosen from operating mode together with requesting source
// R8 - both types hold cpu for 66 watchdog-oscillator then 16 system cycles
// R9 - recovery keeps control registers; system reset restores their reset values
// R10 - pin flag reads one after a pin reset, else zero
// R11 - watchdog flag reads one after a watchdog time-out, else zero
// R12 - recovery flag reads one after a stop recovery, else zero
// R13 - power-on flag reads one after a power-on reset, else zero; code also sets it after a brownout or debugger reset
// R14 - power-on or brownout outranks every source and forces full system reset
// R15 - outside party holds reset pin low at least 4 system cycles
// R16 - debugger reset bit self-clears during reset; debugger logic not reset
// R17 - pin held low past time-out keeps reset; release follows pin release
// R18 - asynchronous requests are synchronised before the latency counters use them
`ifndef RSCR_CONSTS_SVH
`define RSCR_CONSTS_SVH

// -----------------------------------------------------------------------------
// register map (byte addresses)
// -----------------------------------------------------------------------------
`define RSCR_ADDR_STATUS     12'hff0
`define RSCR_ADDR_DBGCTL     12'h100
`define RSCR_ADDR_IRQ_STATUS 12'h104
`define RSCR_ADDR_IRQ_MASK   12'h108
`define RSCR_ADDR_CONFIG     12'h10c
`define RSCR_ADDR_SMR_EN     12'h110

// -----------------------------------------------------------------------------
// status fields
// -----------------------------------------------------------------------------
`define RSCR_ST_POR  7
`define RSCR_ST_STOP 6
`define RSCR_ST_WDT  5
`define RSCR_ST_EXT  4
`define RSCR_ST_RESET 8'h80
`define RSCR_DBG_RST 0
`define RSCR_CFG_WATCHDOG_RESET_OPTION 0

// interrupt status bits
`define RSCR_IRQ_SYS 0
`define RSCR_IRQ_SMR 1
`define RSCR_IRQ_W   2

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define RSCR_WDO_CYCLES 66
`define RSCR_SYS_CYCLES 16
`define RSCR_PIN_MIN    4
`define RSCR_CFG_RESET  32'h0000_0001

`endif

// ==== hdl/rscr_pkg.sv ====
// types of the reset and stop recovery controller
package rscr_pkg;
   typedef enum logic [1:0] {
      rscr_idle,
      rscr_wdo_count,
      rscr_sys_count,
      rscr_pin_hold
   } rscr_state_t;

   typedef enum logic {
      rscr_type_system,
      rscr_type_recovery
   } rscr_type_t;

   typedef struct packed {
      logic por;
      logic brownout;
      logic wdt;
      logic pin;
      logic dbg_rst;
   } rscr_src_t;
endpackage

// ==== hdl/rscr_top.sv ====
// reset and stop recovery controller with apb registers
`timescale 1ns/1ps
`include "rscr_consts.svh"
module rscr_top #(
   parameter int PORT_PINS = 8,
   parameter int WDO_CYCLES = `RSCR_WDO_CYCLES,
   parameter int SYS_CYCLES = `RSCR_SYS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic por_req,
   input wire logic brownout_detect,
   input wire logic wdt_timeout,
   input wire logic reset_pin_n,
   input wire logic debug_pin_n,
   input wire logic wdo_tick,
   input wire logic stop_mode,
   input wire logic [PORT_PINS-1:0] port_in,
   output logic cpu_reset,
   output logic ctrl_reg_reset,
   output logic recovery_active,
   output logic irq
);
   // ---------------------------------------------------------------------------
   // synchronisers for asynchronous requests
   // ---------------------------------------------------------------------------
   rscr_pkg::rscr_src_t src_meta;
   rscr_pkg::rscr_src_t src_sync;
   logic [1:0] dbgpin_sync;
   logic [PORT_PINS-1:0] port_meta;
   logic [PORT_PINS-1:0] port_sync;
   logic [PORT_PINS-1:0] port_prev;

   // two flops each, three on the port pins; the second stage is used below, the third for port edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_meta <= '0;
         src_sync <= '0;
         dbgpin_sync <= 2'b11;
         port_meta <= '0;
         port_sync <= '0;
         port_prev <= '0;
      end else begin
         src_meta <= '{por: por_req, brownout: brownout_detect, wdt: wdt_timeout,
                       pin: !reset_pin_n, dbg_rst: 1'b0}; // R18
         src_sync <= src_meta;
         dbgpin_sync <= {dbgpin_sync[0], debug_pin_n};
         port_meta <= port_in;
         port_sync <= port_meta;
         port_prev <= port_sync;
      end
   end

   // ---------------------------------------------------------------------------
   // reset pin qualifier: low for four system cycles
   // ---------------------------------------------------------------------------
   logic [2:0] pin_cnt;
   logic pin_valid;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_cnt <= 3'h0;
      end else if (!src_sync.pin) begin
         pin_cnt <= 3'h0;
      end else if (pin_cnt != 3'(`RSCR_PIN_MIN)) begin
         pin_cnt <= pin_cnt + 3'h1;
      end
   end
   assign pin_valid = (pin_cnt == 3'(`RSCR_PIN_MIN)); // R15

   // ---------------------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------------------
   logic [7:0] cause;
   logic dbg_rst;
   logic watchdog_reset_option_opt;
   logic [PORT_PINS-1:0] smr_en;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic wr_acc;
   logic mapped;

   assign wr_acc = psel && penable && pwrite;
   assign pready = 1'b1;

   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == `RSCR_ADDR_STATUS) || (a == `RSCR_ADDR_DBGCTL) ||
                    (a == `RSCR_ADDR_IRQ_STATUS) || (a == `RSCR_ADDR_IRQ_MASK) ||
                    (a == `RSCR_ADDR_CONFIG) || (a == `RSCR_ADDR_SMR_EN);
   endfunction
   assign mapped = addr_mapped(paddr);

   // write hit on one register; only the low byte lane carries the control bits
   function automatic logic wr_hit(input logic acc, input logic [11:0] a, input logic [11:0] target,
                                   input logic lane0);
      wr_hit = acc && (a == target) && lane0;
   endfunction
   assign pslverr = psel && penable && (!mapped || (pwrite && paddr == `RSCR_ADDR_STATUS));

   // ---------------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------------
   rscr_pkg::rscr_state_t state;
   rscr_pkg::rscr_type_t rtype;
   logic [4:0] sys_cnt;
   logic wdo_done;
   logic sys_req;
   logic smr_req;
   logic port_edge;
   logic start;
   logic por_now;

   // only pins with recovery enable count
   assign port_edge = |((port_sync ^ port_prev) & smr_en); // R5
   assign por_now = src_sync.por || src_sync.brownout; // R14
   // the debugger reset bit, like the watchdog, is a system reset only outside stop
   assign sys_req = por_now || (!stop_mode && ((src_sync.wdt && watchdog_reset_option_opt) || dbg_rst)) ||
                    pin_valid; // R1 R2 R7
   assign smr_req = stop_mode && (src_sync.wdt || port_edge || !dbgpin_sync[1]); // R4
   assign start = (state == rscr_pkg::rscr_idle) && (sys_req || smr_req);

   rscr_wdo_counter #(
      .COUNT(WDO_CYCLES)
   ) u_wdo (
      .pclk(pclk),
      .presetn(presetn),
      .start(start),
      .wdo_tick(wdo_tick),
      .done(wdo_done)
   );

   // two reset types, system wins when both requested
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtype <= rscr_pkg::rscr_type_system;
      end else if (start) begin
         rtype <= sys_req ? rscr_pkg::rscr_type_system : rscr_pkg::rscr_type_recovery; // R6 R7
      end else if (state != rscr_pkg::rscr_idle && por_now) begin
         rtype <= rscr_pkg::rscr_type_system; // R14
      end
   end

   // oscillator phase, then system-clock phase, then hold while pin stays low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= rscr_pkg::rscr_idle;
         sys_cnt <= 5'h00;
      end else begin
         unique case (state)
            rscr_pkg::rscr_idle: begin
               if (start) begin
                  state <= rscr_pkg::rscr_wdo_count;
               end
            end
            rscr_pkg::rscr_wdo_count: begin
               sys_cnt <= 5'h00;
               if (wdo_done) begin
                  state <= rscr_pkg::rscr_sys_count; // R8
               end
            end
            rscr_pkg::rscr_sys_count: begin
               if (sys_cnt == 5'(SYS_CYCLES - 1)) begin // R8
                  state <= src_sync.pin ? rscr_pkg::rscr_pin_hold : rscr_pkg::rscr_idle; // R17
               end else begin
                  sys_cnt <= sys_cnt + 5'h01;
               end
            end
            rscr_pkg::rscr_pin_hold: begin
               if (!src_sync.pin) begin
                  state <= rscr_pkg::rscr_idle; // R17
               end
            end
         endcase
      end
   end

   // cpu held for the whole sequence; control registers only on system type
   assign cpu_reset = (state != rscr_pkg::rscr_idle);
   assign ctrl_reg_reset = cpu_reset && (rtype == rscr_pkg::rscr_type_system); // R9
   assign recovery_active = cpu_reset && (rtype == rscr_pkg::rscr_type_recovery);

   logic seq_end;
   assign seq_end = cpu_reset && !(state == rscr_pkg::rscr_sys_count && sys_cnt != 5'(SYS_CYCLES - 1))
                    && (state == rscr_pkg::rscr_sys_count ? !src_sync.pin : state == rscr_pkg::rscr_pin_hold
                        && !src_sync.pin);

   // ---------------------------------------------------------------------------
   // cause register: recorded at start of each sequence
   // ---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= `RSCR_ST_RESET;
      end else if (start) begin
         cause <= 8'h00;
         cause[`RSCR_ST_POR] <= sys_req && (por_now || (dbg_rst && !stop_mode)); // R13
         cause[`RSCR_ST_STOP] <= !sys_req; // R12
         cause[`RSCR_ST_WDT] <= src_sync.wdt; // R11
         cause[`RSCR_ST_EXT] <= pin_valid && !por_now; // R10
      end
   end

   // ---------------------------------------------------------------------------
   // debugger control: cleared while the cpu is held in the reset it causes
   // ---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_rst <= 1'b0;
      end else if (wr_hit(wr_acc, paddr, `RSCR_ADDR_DBGCTL, pstrb[0])) begin
         dbg_rst <= pwdata[`RSCR_DBG_RST]; // R3
      end else if (cpu_reset) begin
         dbg_rst <= 1'b0; // R16
      end
   end

   // configuration and port enables return to defaults on a system reset only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_reset_option_opt <= 1'(`RSCR_CFG_RESET);
         smr_en <= '0;
      end else if (ctrl_reg_reset) begin
         watchdog_reset_option_opt <= 1'(`RSCR_CFG_RESET); // R9
         smr_en <= '0;
      end else if (wr_acc && pstrb[0]) begin
         if (paddr == `RSCR_ADDR_CONFIG) begin
            watchdog_reset_option_opt <= pwdata[`RSCR_CFG_WATCHDOG_RESET_OPTION];
         end
         if (paddr == `RSCR_ADDR_SMR_EN) begin
            smr_en <= pwdata[PORT_PINS-1:0];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // interrupts: sticky, write one to clear, set beats clear
   // ---------------------------------------------------------------------------
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   assign irq_set = {start && src_sync.wdt, seq_end && recovery_active, seq_end && ctrl_reg_reset};
   assign irq_clr = wr_hit(wr_acc, paddr, `RSCR_ADDR_IRQ_STATUS, pstrb[0]) ? pwdata[2:0] : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 3'h0;
         irq_mask <= 3'h0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_hit(wr_acc, paddr, `RSCR_ADDR_IRQ_MASK, pstrb[0])) begin
            irq_mask <= pwdata[2:0];
         end
      end
   end
   assign irq = |(irq_status & irq_mask);

   // ---------------------------------------------------------------------------
   // read data registered in setup phase, valid in access phase
   // ---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `RSCR_ADDR_STATUS: prdata <= {24'h000000, cause};
            `RSCR_ADDR_DBGCTL: prdata <= {31'h00000000, dbg_rst};
            `RSCR_ADDR_IRQ_STATUS: prdata <= {29'h00000000, irq_status};
            `RSCR_ADDR_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
            `RSCR_ADDR_CONFIG: prdata <= {31'h00000000, watchdog_reset_option_opt};
            `RSCR_ADDR_SMR_EN: prdata <= 32'(smr_en);
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // rscr_top

// ==== hdl/rscr_wdo_counter.sv ====
// latency counter running on the watchdog oscillator tick
`timescale 1ns/1ps
module rscr_wdo_counter #(
   parameter int COUNT = 66
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic wdo_tick,
   output logic done
);
   logic [7:0] cnt;
   logic running;

   // ---------------------------------------------------------------------------
   // count oscillator ticks after start, pulse done at the last one
   // ---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt <= 8'h00;
            running <= 1'b1;
         end else if (running && wdo_tick) begin
            if (cnt == 8'(COUNT - 1)) begin // R8
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule // rscr_wdo_counter

// ==== sim/rscr_assertions.sv ====
// port checker of the reset and stop recovery controller
`timescale 1ns/1ps
module rscr_assertions #(
   parameter int PORT_PINS = 8,
   parameter int WDO_CYCLES = 66,
   parameter int SYS_CYCLES = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic por_req,
   input wire logic reset_pin_n,
   input wire logic stop_mode,
   input wire logic wdo_tick,
   input wire logic cpu_reset,
   input wire logic ctrl_reg_reset,
   input wire logic recovery_active,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] n_tick;
   logic [7:0] n_sys;
   // ticks seen, and cycles since the oscillator count was reached, while the cpu is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_tick <= 8'h00;
         n_sys <= 8'h00;
      end else if (!cpu_reset) begin
         n_tick <= 8'h00;
         n_sys <= 8'h00;
      end else begin
         n_tick <= n_tick + {7'h00, wdo_tick};
         // the oscillator keeps ticking in the system phase, so later ticks must not restart this count
         n_sys <= (n_tick >= 8'(WDO_CYCLES)) ? n_sys + 8'h01 : 8'h00;
      end
   end
   sequence s_por_held; por_req [*6]; endsequence
   sequence s_pin_held; !reset_pin_n [*8]; endsequence
   a_ready_always: assert property (psel && penable |-> pready) else $error("access without ready");
   a_status_readonly: assert property (psel && penable && pwrite && paddr == 12'hff0 |-> pslverr)
      else $error("status write not refused");
   a_one_type: assert property (cpu_reset == (ctrl_reg_reset ^ recovery_active))
      else $error("reset type not exactly one");
   a_wdo_latency: assert property ($fell(cpu_reset) |-> n_tick >= WDO_CYCLES - 1)
      else $error("released before oscillator count");
   a_sys_latency: assert property ($fell(cpu_reset) |-> n_sys >= SYS_CYCLES)
      else $error("released before system count");
   a_pin_release: assert property ($fell(cpu_reset) |-> $past(reset_pin_n))
      else $error("released while pin low");
   a_por_system: assert property (s_por_held |-> cpu_reset && ctrl_reg_reset)
      else $error("power request without system reset");
   a_pin_start: assert property (s_pin_held |-> cpu_reset)
      else $error("pin low without reset");
   a_rec_in_stop: assert property ($rose(recovery_active) |-> $past(stop_mode))
      else $error("recovery outside stop");
   a_mask_quiet: assert property (psel && penable && pwrite && pstrb[0] && paddr == 12'h108
      && pwdata[2:0] == 3'h0 |=> !irq) else $error("irq with all masked");
endmodule // rscr_assertions

bind rscr_top rscr_assertions #(.PORT_PINS(PORT_PINS), .WDO_CYCLES(WDO_CYCLES), .SYS_CYCLES(SYS_CYCLES)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .por_req(por_req),
   .reset_pin_n(reset_pin_n), .stop_mode(stop_mode), .wdo_tick(wdo_tick), .cpu_reset(cpu_reset),
   .ctrl_reg_reset(ctrl_reg_reset), .recovery_active(recovery_active), .irq(irq));

// ==== sim/rscr_partner.sv ====
// far-side model: watchdog oscillator ticks and the reset pin
`timescale 1ns/1ps
module rscr_partner (
   input wire logic pclk,
   input wire logic pin_go,
   input wire logic [7:0] pin_len,
   output logic wdo_tick,
   output logic reset_pin_n
);
   logic [1:0] div = 2'h0;
   logic [7:0] left = 8'h00;
   // oscillator runs through reset, so it takes no reset input
   always @(posedge pclk) begin
      div <= div + 2'h1;
   end
   assign wdo_tick = (div == 2'h3);
   // pin held low for the asked count, pulled up otherwise; short counts break the minimum on purpose
   always @(posedge pclk) begin
      if (pin_go) begin
         left <= pin_len;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign reset_pin_n = (left == 8'h00);
endmodule // rscr_partner

// ==== sim/rscr_top_bench.sv ====
// self-checking bench of the reset and stop recovery controller
`timescale 1ns/1ps
module rscr_top_bench;
   localparam int WDO = 3;
   localparam int SYS = 4;
   localparam int LO = WDO * 4 + SYS - 4;
   localparam int HI = WDO * 4 + SYS + 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_go = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, err, wdo_tick, reset_pin_n, cpu_reset, ctrl_reg_reset, recovery_active, irq;
   logic por_req = 1'b0, brownout_detect = 1'b0, wdt_timeout = 1'b0, debug_pin_n = 1'b1, stop_mode = 1'b0;
   logic [7:0] port_in = 8'h00, pin_len = 8'h00;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   // source, length, stop, watchdog option, type (0 none 1 recovery 2 system), status, status mask
   int tc[14][7] = '{
      '{0, 8, 0, 1, 2, 8'h80, 8'hff},
      '{1, 8, 1, 1, 2, 8'h80, 8'hff},
      '{2, 4, 0, 1, 2, 8'h20, 8'hff},
      '{2, 4, 0, 0, 0, 0, 0},
      '{6, 3, 0, 1, 0, 0, 0},
      '{6, 6, 0, 1, 2, 8'h10, 8'hff},
      '{6, 6, 1, 1, 2, 8'h10, 8'hff},
      '{6, 60, 0, 1, 2, 8'h10, 8'hff},
      '{7, 1, 0, 1, 2, 8'h80, 8'hff},
      '{3, 4, 1, 1, 1, 8'h40, 8'h40},
      '{3, 4, 0, 1, 0, 0, 0},
      '{4, 1, 1, 1, 0, 0, 0},
      '{2, 4, 1, 1, 1, 8'h40, 8'h40},
      '{5, 1, 1, 1, 1, 8'h40, 8'h40}};
   rscr_top #(.WDO_CYCLES(WDO), .SYS_CYCLES(SYS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .por_req(por_req), .brownout_detect(brownout_detect),
      .wdt_timeout(wdt_timeout), .reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n), .wdo_tick(wdo_tick),
      .stop_mode(stop_mode), .port_in(port_in), .cpu_reset(cpu_reset), .ctrl_reg_reset(ctrl_reg_reset),
      .recovery_active(recovery_active), .irq(irq));
   rscr_partner u_far (.pclk(pclk), .pin_go(pin_go), .pin_len(pin_len), .wdo_tick(wdo_tick),
      .reset_pin_n(reset_pin_n));
   // clock and hang guard; a hang counts as a mismatch
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out();
      $display("counts: %0d mismatches in %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk); // idle cycle, so a following call never re-drives psel in the same step
   endtask
   // fire one source, watch the sequence, then check type, length and registers
   task automatic run(input int r);
      int t, up, dn, lo, hi;
      up = -1;
      dn = -1;
      lo = (tc[r][1] > 20) ? tc[r][1] - 12 : LO;
      hi = (tc[r][1] > 20) ? tc[r][1] + 2 : HI;
      apb(1'b1, 12'h10c, 32'(tc[r][3]));
      apb(1'b1, 12'h110, 32'h1);
      stop_mode <= (tc[r][2] != 0);
      @(posedge pclk);
      case (tc[r][0])
         0: por_req <= 1'b1;
         1: brownout_detect <= 1'b1;
         2: wdt_timeout <= 1'b1;
         3: debug_pin_n <= 1'b0;
         4: port_in <= 8'h02;
         5: port_in <= 8'h01;
         6: begin
            pin_len <= 8'(tc[r][1]);
            pin_go <= 1'b1;
         end
         default: apb(1'b1, 12'h100, 32'h1);
      endcase
      for (t = 0; t < 120 && dn < 0; t++) begin
         @(posedge pclk);
         pin_go <= 1'b0;
         if (t == tc[r][1]) begin
            por_req <= 1'b0;
            brownout_detect <= 1'b0;
            wdt_timeout <= 1'b0;
            debug_pin_n <= 1'b1;
         end
         if (cpu_reset === 1'b1 && up < 0) begin
            up = t;
            chk({30'h0, ctrl_reg_reset, recovery_active}, (tc[r][4] == 2) ? 32'h2 : 32'h1);
         end
         if (cpu_reset !== 1'b1 && up >= 0) dn = t;
      end
      stop_mode <= 1'b0;
      port_in <= 8'h00;
      repeat (3) @(posedge pclk);
      if (tc[r][4] == 0) begin
         chk({31'h0, up < 0}, 32'h1);
      end else begin
         chk({31'h0, dn - up >= lo && dn - up <= hi}, 32'h1);
         apb(1'b0, 12'hff0, 32'h0);
         chk(rd & 32'(tc[r][6]), 32'(tc[r][5]));
      end
      apb(1'b0, 12'h110, 32'h0);
      chk(rd, (tc[r][4] == 2) ? 32'h0 : 32'h1);
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      $display("case %0d done", r);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'hff0, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, 12'h10c, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 12'hff0, 32'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h200, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("register test done");
      for (int r = 0; r < 14; r++) run(r);
      // recovery leaves its event bit set: unmask, mask, clear
      apb(1'b1, 12'h108, 32'h2);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h108, 32'h0);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h108, 32'h2);
      apb(1'b1, 12'h104, 32'h2);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, 12'h104, 32'h0);
      chk(rd & 32'h2, 32'h0);
      $display("interrupt test done");
      close_out();
   end
endmodule // rscr_top_bench
